// [shared/gia_pkg.sv]
package gia_pkg;

    // ------------------------------------------------------------------
    // Bit positions; byte bit 0 is the most significant line.
    // ------------------------------------------------------------------
    localparam int ST_CE    = 3;  // Status bit 4, channel end.
    localparam int ST_DE    = 2;  // Status bit 5, device end.
    localparam int ST_UC    = 1;  // Status bit 6, unit check.
    localparam int SN_REJ   = 7;  // Sense bit 0, command reject.
    localparam int SN_BOC   = 5;  // Sense bit 2, bus out check.
    localparam int SN_DCK   = 3;  // Sense bit 4, data check.
    localparam int CMD_MOD0 = 7;  // Modifier bit 0, output gate.
    localparam int CMD_MOD1 = 6;  // Modifier bit 1, control line 1.
    localparam int CMD_MOD3 = 4;  // Modifier bit 3, control line 3.
    localparam int CMD_MOD4 = 3;  // Modifier bit 4, control line 4.

    // ------------------------------------------------------------------
    // Command codes and widths.
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_TEST_IO    = 8'h00;  // Test I/O.
    localparam logic [7:0] CMD_NOOP       = 8'h03;  // Control no-op.
    localparam logic [7:0] CMD_SENSE      = 8'h04;  // Sense.
    localparam logic [7:0] CMD_READ_MASK  = 8'ha7;  // Fixed read bits.
    localparam logic [7:0] CMD_READ_VAL   = 8'h82;  // Read pattern.
    localparam logic [7:0] CMD_TREAD_MASK = 8'h27;  // Fixed test bits.
    localparam logic [7:0] CMD_TREAD_VAL  = 8'h22;  // Test read pattern.
    localparam logic [7:0] BYTE_ZERO      = 8'h00;  // Empty byte.
    localparam int         DATA_WIDTH     = 8;      // Device data lines.
    localparam int         FIFO_DEPTH     = 4;      // Inbound buffer words.

    // ------------------------------------------------------------------
    // Carriers and state.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;     // Data lines.
        logic       parity;   // Parity line.
        logic       request;  // Transfer request line.
        logic       eom;      // End-of-message line.
    } gia_dev_in_t;

    typedef struct packed {
        logic [7:0] data;     // Byte value.
        logic       parity;   // Odd parity of the byte.
    } gia_byte_t;

    typedef enum logic [1:0] {
        GIA_IDLE,
        GIA_SENSE,
        GIA_READ,
        GIA_TEST
    } gia_phase_t;

    typedef struct packed {
        gia_phase_t  phase;         // Operation in progress.
        gia_dev_in_t dev_s1;        // Device pins, first stage.
        gia_dev_in_t dev_s2;        // Device pins, second stage.
        gia_dev_in_t tst_s1;        // Test lines, first stage.
        gia_dev_in_t tst_s2;        // Test lines, second stage.
        gia_byte_t   status;        // Status byte with parity.
        gia_byte_t   sense;         // Sense byte with parity.
        gia_byte_t   sel_status;    // Initial selection status.
        gia_byte_t   bus_in;        // Byte on the inbound bus.
        logic        sel_ack;       // Selection answer pulse.
        logic        bus_in_valid;  // Inbound byte presented.
        logic        svc_req;       // Service request to channel.
        logic        status_req;    // Queued status waiting.
        logic        gate;          // Second output gate.
        logic [2:0]  ctrl;          // Control lines 1, 3, 4.
        logic        response;      // Response to the device.
        logic        test_resp;     // Response on the test lines.
        logic [7:0]  prio;          // Service priority address.
    } gia_state_t;

    localparam gia_state_t STATE_RESET = '0;

    // Odd parity bit for a byte.
    function automatic logic odd_par(input logic [7:0] b);
        odd_par = ~(^b);
    endfunction : odd_par

endpackage : gia_pkg

// [rtl/gia_adapter.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Inbound buffer
// ----------------------------------------------------------------------
// Holds sampled device bytes until the channel takes them.
module gia_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words.
        logic [AW-1:0]               wr;   // Write pointer.
        logic [AW-1:0]               rd;   // Read pointer.
        logic [AW:0]                 cnt;  // Words held.
    } gia_fifo_state_t;

    gia_fifo_state_t s;       // Registered state.
    gia_fifo_state_t next_s;  // Next state.
    logic            push;    // Word written this cycle.
    logic            pop;     // Word read this cycle.

    assign in_ready_o  = (s.cnt != FULL);
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = s.mem[s.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    // Pointer and count update; a flush empties the buffer.
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data_i;
            next_s.wr = (s.wr == LAST) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
        if (flush_i) begin
            next_s.wr  = '0;
            next_s.rd  = '0;
            next_s.cnt = '0;
        end
    end

    // State register.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : gia_fifo

// ----------------------------------------------------------------------
// General input adapter
// ----------------------------------------------------------------------
module gia_adapter #(
    parameter logic [7:0] ADDRESS     = 8'h00,  // Assigned address.
    parameter int         DATA_BITS   = 8,      // Data lines in use.
    parameter bit         PARITY_USED = 1'b1,   // Device sends parity.
    parameter bit         ODD_PARITY  = 1'b1    // Parity sense jumper.
) (
    input  wire logic                clock_i,
    input  wire logic                reset_i,
    input  wire logic                sel_i,
    input  wire logic [7:0]          cmd_i,
    input  wire logic                bus_out_check_i,
    input  wire logic                status_accept_i,
    input  wire logic                service_grant_i,
    input  wire logic                bus_in_accept_i,
    input  wire logic                stop_i,
    input  wire logic                halt_i,
    input  gia_pkg::gia_dev_in_t     dev_in_i,
    input  gia_pkg::gia_dev_in_t     test_in_i,
    output logic                     sel_ack_o,
    output gia_pkg::gia_byte_t       sel_status_o,
    output gia_pkg::gia_byte_t       status_o,
    output gia_pkg::gia_byte_t       sense_o,
    output logic                     status_req_o,
    output logic                     service_req_o,
    output logic                     bus_in_valid_o,
    output gia_pkg::gia_byte_t       bus_in_o,
    output logic [7:0]               priority_o,
    output logic                     dev_response_o,
    output logic [2:0]               dev_ctrl_o,
    output logic                     test_resp_o
);
    // Used positions are the low order lines; the rest stay zero.
    localparam logic [7:0] USE_MASK = 8'((9'h001 << DATA_BITS) - 9'h001);

    gia_pkg::gia_state_t s;           // Registered state.
    gia_pkg::gia_state_t next_s;      // Next state.
    logic                fifo_push;   // Sampled byte enters buffer.
    logic                fifo_ready;  // Buffer has room.
    logic                fifo_valid;  // Buffer holds a byte.
    logic                fifo_pop;    // Channel took the byte.
    logic                fifo_flush;  // Drop buffered bytes.
    gia_pkg::gia_byte_t  fifo_in;     // Byte into the buffer.
    gia_pkg::gia_byte_t  fifo_out;    // Byte out of the buffer.

    // ------------------------------------------------------------------
    // Inbound buffer instance
    // ------------------------------------------------------------------
    gia_fifo #(
        .WIDTH (gia_pkg::DATA_WIDTH + 1),
        .DEPTH (gia_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .flush_i     (fifo_flush),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Selection, device handshake, channel service and status in one
    // pass; status sets follow the acceptance clear so an event always wins.
    always_comb begin
        logic               ce_set;      // Set channel and device end.
        logic               uc_set;      // Set unit check.
        logic               st_clr;      // Status accepted.
        logic               terminate;   // End current operation.
        logic               active;      // Read or test read running.
        logic               req_seen;    // Request with response low.
        logic               bad_par;     // Device byte parity wrong.
        logic [7:0]         sense_v;     // Working sense bits.
        logic [7:0]         stat_v;      // Working status bits.
        logic [7:0]         masked;      // Data with unused lines zero.
        gia_pkg::gia_dev_in_t src;       // Active input lines.
        ce_set    = 1'b0;
        uc_set    = 1'b0;
        req_seen  = 1'b0;
        stat_v    = gia_pkg::BYTE_ZERO;
        st_clr    = status_accept_i;
        terminate = 1'b0;
        active    = (s.phase == gia_pkg::GIA_READ) ||
                    (s.phase == gia_pkg::GIA_TEST);
        src       = (s.phase == gia_pkg::GIA_TEST) ? s.tst_s2 : s.dev_s2;
        masked    = src.data & USE_MASK;
        bad_par   = PARITY_USED &&
                    ((^{masked, src.parity}) != ODD_PARITY);
        sense_v   = s.sense.data;
        fifo_push = 1'b0;
        fifo_pop  = 1'b0;
        fifo_flush = 1'b0;
        fifo_in   = '{data: masked, parity: gia_pkg::odd_par(masked)};
        next_s    = s;

        // Pins pass two flip-flops before any use.
        next_s.dev_s1  = dev_in_i;
        next_s.dev_s2  = s.dev_s1;
        next_s.tst_s1  = test_in_i;
        next_s.tst_s2  = s.tst_s1;
        next_s.sel_ack = 1'b0;
        next_s.prio    = ADDRESS;

        // Responses follow their request down.
        next_s.response  = s.response && s.dev_s2.request;
        next_s.test_resp = s.test_resp && s.tst_s2.request;

        // Device handshake while a read is selected.
        req_seen = active && src.request &&
                   !((s.phase == gia_pkg::GIA_TEST) ? s.test_resp
                                                    : s.response);
        if (req_seen && !fifo_valid && fifo_ready &&
                !s.bus_in_valid) begin
            if (s.phase == gia_pkg::GIA_TEST) begin
                next_s.test_resp = 1'b1;
            end else begin
                next_s.response = s.gate;
            end
            if (src.eom) begin
                terminate = 1'b1;
            end else begin
                fifo_push = 1'b1;
                if (bad_par) begin
                    sense_v[gia_pkg::SN_DCK] = 1'b1;
                end
            end
        end

        // Service toward the channel.
        if (s.bus_in_valid && bus_in_accept_i) begin
            next_s.bus_in_valid = 1'b0;
            if (s.phase == gia_pkg::GIA_SENSE) begin
                terminate = 1'b1;
            end else begin
                fifo_pop = 1'b1;
            end
        end else if (s.svc_req && service_grant_i) begin
            next_s.bus_in_valid = 1'b1;
            next_s.bus_in = (s.phase == gia_pkg::GIA_SENSE) ?
                            s.sense : fifo_out;
        end

        // Channel stops the transfer at zero count.
        if (active && stop_i) begin
            terminate       = 1'b1;
            fifo_flush      = 1'b1;
            next_s.bus_in_valid = 1'b0;
            next_s.response  = 1'b0;
            next_s.test_resp = 1'b0;
        end

        // Halt ends any operation.
        if (halt_i && (s.phase != gia_pkg::GIA_IDLE)) begin
            terminate       = 1'b1;
            fifo_flush      = 1'b1;
            next_s.bus_in_valid = 1'b0;
        end

        // Termination sequence.
        if (terminate) begin
            ce_set = 1'b1;
            if (active && sense_v[gia_pkg::SN_DCK]) begin
                uc_set = 1'b1;
            end
            next_s.phase = gia_pkg::GIA_IDLE;
            next_s.ctrl  = 3'h0;
            next_s.gate  = 1'b0;
        end

        // Initial selection.
        if (sel_i) begin
            next_s.sel_ack = 1'b1;
            if (bus_out_check_i) begin
                sense_v = gia_pkg::BYTE_ZERO;
                uc_set  = 1'b1;
            end else if (s.phase != gia_pkg::GIA_IDLE) begin
                // Busy: answer with present status, leave it running.
            end else if (cmd_i == gia_pkg::CMD_TEST_IO) begin
                // Pending status is returned below as it stands.
            end else if (cmd_i == gia_pkg::CMD_NOOP) begin
                ce_set = 1'b1;
            end else if (cmd_i == gia_pkg::CMD_SENSE) begin
                next_s.phase = gia_pkg::GIA_SENSE;
            end else if ((cmd_i & gia_pkg::CMD_READ_MASK) ==
                         gia_pkg::CMD_READ_VAL) begin
                sense_v      = gia_pkg::BYTE_ZERO;
                next_s.phase = gia_pkg::GIA_READ;
                next_s.gate  = cmd_i[gia_pkg::CMD_MOD0];
                next_s.ctrl  = {cmd_i[gia_pkg::CMD_MOD4],
                                cmd_i[gia_pkg::CMD_MOD3],
                                cmd_i[gia_pkg::CMD_MOD1]} &
                               {3{cmd_i[gia_pkg::CMD_MOD0]}};
            end else if ((cmd_i & gia_pkg::CMD_TREAD_MASK) ==
                         gia_pkg::CMD_TREAD_VAL) begin
                sense_v      = gia_pkg::BYTE_ZERO;
                next_s.phase = gia_pkg::GIA_TEST;
                next_s.gate  = 1'b0;
                next_s.ctrl  = 3'h0;
            end else begin
                sense_v = gia_pkg::BYTE_ZERO;
                sense_v[gia_pkg::SN_REJ] = 1'b1;
                uc_set  = 1'b1;
            end
        end

        // Bus out check is recorded at any time.
        if (bus_out_check_i) begin
            sense_v[gia_pkg::SN_BOC] = 1'b1;
        end
        next_s.sense = '{data: sense_v,
                         parity: gia_pkg::odd_par(sense_v)};

        // Status bits: acceptance clears, new events win.
        stat_v = st_clr ? gia_pkg::BYTE_ZERO : s.status.data;
        if (ce_set) begin
            stat_v[gia_pkg::ST_CE] = 1'b1;
            stat_v[gia_pkg::ST_DE] = 1'b1;
        end
        if (uc_set) begin
            stat_v[gia_pkg::ST_UC] = 1'b1;
        end
        next_s.status = '{data: stat_v,
                          parity: gia_pkg::odd_par(stat_v)};
        if (sel_i) begin
            next_s.sel_status = next_s.status;
        end
        next_s.status_req = (stat_v != gia_pkg::BYTE_ZERO) &&
                            !sel_i;

        // Request service while a byte waits to go in.
        next_s.svc_req = !next_s.bus_in_valid && !terminate &&
                         (((next_s.phase == gia_pkg::GIA_READ) ||
                           (next_s.phase == gia_pkg::GIA_TEST)) &&
                          (fifo_valid || fifo_push) && !fifo_pop ||
                          (next_s.phase == gia_pkg::GIA_SENSE));
        if (s.svc_req && service_grant_i) begin
            next_s.svc_req = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // One register holds the adapter state; the inbound buffer has its own.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s <= gia_pkg::STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from the state register
    // ------------------------------------------------------------------
    assign sel_ack_o      = s.sel_ack;
    assign sel_status_o   = s.sel_status;
    assign status_o       = s.status;
    assign sense_o        = s.sense;
    assign status_req_o   = s.status_req;
    assign service_req_o  = s.svc_req;
    assign bus_in_valid_o = s.bus_in_valid;
    assign bus_in_o       = s.bus_in;
    assign priority_o     = s.prio;
    assign dev_response_o = s.response;
    assign dev_ctrl_o     = s.ctrl;
    assign test_resp_o    = s.test_resp;
endmodule : gia_adapter

// [dv/gia_adapter_props.sv]
`timescale 1ns/100ps
// Port checker for the adapter, bound to its top module.
module gia_adapter_props #(
    parameter logic [7:0] ADDRESS = 8'h00
) (
    input wire logic            clock_i,
    input wire logic            reset_i,
    input wire logic            sel_i,
    input wire logic            bus_out_check_i,
    input wire logic            service_grant_i,
    input wire logic            bus_in_accept_i,
    input wire logic            stop_i,
    input wire logic            halt_i,
    input gia_pkg::gia_dev_in_t dev_in_i,
    input wire logic            sel_ack_o,
    input gia_pkg::gia_byte_t   sel_status_o,
    input gia_pkg::gia_byte_t   status_o,
    input gia_pkg::gia_byte_t   sense_o,
    input wire logic            service_req_o,
    input wire logic            bus_in_valid_o,
    input gia_pkg::gia_byte_t   bus_in_o,
    input wire logic [7:0]      priority_o,
    input wire logic            dev_response_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_sel; sel_i |=> sel_ack_o; endproperty
    a_sel: assert property (p_sel)
        else $error("selection not answered");
    property p_cede;
        status_o.data[gia_pkg::ST_CE] == status_o.data[gia_pkg::ST_DE];
    endproperty
    a_cede: assert property (p_cede)
        else $error("channel end and device end split");
    property p_par; bus_in_valid_o |-> bus_in_o.parity == ~(^bus_in_o.data);
    endproperty
    a_par: assert property (p_par)
        else $error("inbound parity wrong");
    property p_hold;
        bus_in_valid_o && !bus_in_accept_i && !stop_i && !halt_i
            |=> bus_in_valid_o && $stable(bus_in_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("inbound byte not held");
    property p_grant; service_req_o && service_grant_i
        |=> bus_in_valid_o && !service_req_o; endproperty
    a_grant: assert property (p_grant)
        else $error("grant not served");
    property p_boc; sel_i && bus_out_check_i |=> sense_o.data == 8'h20
        && sel_status_o.data[gia_pkg::ST_UC]; endproperty
    a_boc: assert property (p_boc)
        else $error("bus check not reported");
    property p_drop; $fell(dev_in_i.request) |-> ##[1:4] !dev_response_o;
    endproperty
    a_drop: assert property (p_drop)
        else $error("response not dropped");
    property p_uc; $rose(status_o.data[gia_pkg::ST_UC])
        |-> sel_ack_o || status_o.data[gia_pkg::ST_CE]; endproperty
    a_uc: assert property (p_uc)
        else $error("unit check raised out of place");
    property p_prio; !reset_i [*2] |=> priority_o == ADDRESS; endproperty
    a_prio: assert property (p_prio)
        else $error("priority differs from address");
    c_sel: cover property (sel_ack_o);
    c_byte: cover property (bus_in_valid_o && bus_in_accept_i);
    c_uc: cover property ($rose(status_o.data[gia_pkg::ST_UC]));
endmodule : gia_adapter_props

bind gia_adapter gia_adapter_props #(.ADDRESS(ADDRESS)) i_gia_adapter_props (
    .clock_i(clock_i), .reset_i(reset_i), .sel_i(sel_i),
    .bus_out_check_i(bus_out_check_i), .service_grant_i(service_grant_i),
    .bus_in_accept_i(bus_in_accept_i), .stop_i(stop_i), .halt_i(halt_i),
    .dev_in_i(dev_in_i), .sel_ack_o(sel_ack_o), .sel_status_o(sel_status_o),
    .status_o(status_o), .sense_o(sense_o), .service_req_o(service_req_o),
    .bus_in_valid_o(bus_in_valid_o), .bus_in_o(bus_in_o),
    .priority_o(priority_o), .dev_response_o(dev_response_o));

// [dv/gia_device_model.sv]
`timescale 1ns/100ps
// Input device: one full request cycle per byte or end-of-message.
module gia_device_model (
    input  wire logic            clock_i,
    input  wire logic            response_i,
    output gia_pkg::gia_dev_in_t dev_o
);
    initial dev_o = '0;
    // Sends one unit after gap + 1 falling clock edges; bad flips the parity line.
    task automatic send(input logic [7:0] d, input logic bad,
                        input logic eom, input int gap);
        int n;
        n = 0;
        repeat (gap + 1) @(negedge clock_i);
        dev_o = '{d, ~(^d) ^ bad, 1'b1, eom};
        while (!response_i && n < 300) begin
            @(negedge clock_i);
            n++;
        end
        dev_o = '{~d, ^d ^ bad, 1'b0, 1'b0};
        while (response_i && n < 600) begin
            @(negedge clock_i);
            n++;
        end
    endtask : send
endmodule : gia_device_model

// [dv/tb_gia_adapter.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_gia_adapter;
    logic clock_i, reset_i, sel_i, bus_out_check_i, status_accept_i;
    logic service_grant_i, bus_in_accept_i, stop_i, halt_i;
    logic sel_ack_o, status_req_o, service_req_o, bus_in_valid_o;
    logic dev_response_o, test_resp_o;
    logic [7:0] cmd_i, priority_o;
    logic [2:0] dev_ctrl_o;
    gia_pkg::gia_dev_in_t dev_in_i, test_in_i;
    gia_pkg::gia_byte_t sel_status_o, status_o, sense_o, bus_in_o;
    int failures = 0;
    int tests_run = 0;
    gia_adapter #(.ADDRESS(8'h05), .DATA_BITS(6)) i_gia_adapter (
        .clock_i(clock_i), .reset_i(reset_i), .sel_i(sel_i), .cmd_i(cmd_i),
        .bus_out_check_i(bus_out_check_i), .status_accept_i(status_accept_i),
        .service_grant_i(service_grant_i), .bus_in_accept_i(bus_in_accept_i),
        .stop_i(stop_i), .halt_i(halt_i), .dev_in_i(dev_in_i),
        .test_in_i(test_in_i), .sel_ack_o(sel_ack_o), .status_o(status_o),
        .sel_status_o(sel_status_o), .sense_o(sense_o), .bus_in_o(bus_in_o),
        .status_req_o(status_req_o), .service_req_o(service_req_o),
        .bus_in_valid_o(bus_in_valid_o), .priority_o(priority_o),
        .dev_response_o(dev_response_o), .dev_ctrl_o(dev_ctrl_o),
        .test_resp_o(test_resp_o));
    gia_device_model i_gia_device_model (.clock_i(clock_i),
        .response_i(dev_response_o), .dev_o(dev_in_i));
    gia_device_model i_gia_device_model_tst (.clock_i(clock_i),
        .response_i(test_resp_o), .dev_o(test_in_i));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Selects with a command and checks the one-cycle answer.
    task automatic sel(input logic [7:0] c, input logic boc);
        @(negedge clock_i);
        {sel_i, cmd_i, bus_out_check_i} = {1'b1, c, boc};
        @(negedge clock_i);
        {sel_i, bus_out_check_i} = 2'b00;
        `CHK("sel_ack", 1'b1, sel_ack_o)
    endtask : sel
    // Channel takes the status byte, which must then be empty.
    task automatic acc();
        status_accept_i = 1'b1;
        @(negedge clock_i);
        status_accept_i = 1'b0;
        @(negedge clock_i);
        `CHK("status clear", 8'h00, status_o.data)
    endtask : acc
    task automatic wsvc();
        for (int n = 0; n < 100 && service_req_o !== 1'b1; n++)
            @(negedge clock_i);
    endtask : wsvc
    // Grants service, stalls a cycle, then accepts the inbound byte.
    task automatic serve(input logic [7:0] e);
        wsvc();
        service_grant_i = 1'b1;
        @(negedge clock_i);
        service_grant_i = 1'b0;
        @(negedge clock_i);
        `CHK("byte", e, bus_in_o.data)
        `CHK("parity", ~(^e), bus_in_o.parity)
        bus_in_accept_i = 1'b1;
        @(negedge clock_i);
        bus_in_accept_i = 1'b0;
    endtask : serve
    task automatic t_select();
        sel(8'h03, 1'b0);
        `CHK("noop", 8'h0c, sel_status_o.data)
        @(negedge clock_i);
        `CHK("queued", 1'b1, status_req_o)
        acc();
        sel(8'h01, 1'b0);
        `CHK("reject", 8'h80, sense_o.data)
        sel(8'h00, 1'b0);
        `CHK("pending", 8'h02, sel_status_o.data)
        acc();
        sel(8'h00, 1'b0);
        `CHK("test io", 8'h00, sel_status_o.data)
        sel(8'h03, 1'b1);
        `CHK("bus check", 8'h20, sense_o.data)
        `CHK("ignored", 8'h02, sel_status_o.data)
        acc();
        sel(8'h04, 1'b0);
        serve(8'h20);
        @(negedge clock_i);
        `CHK("sense end", 8'h0c, status_o.data)
        acc();
        $display("test selection done");
    endtask : t_select
    task automatic t_read();
        sel(8'hd2, 1'b0);
        `CHK("sense reset", 8'h00, sense_o.data)
        `CHK("ctrl", 3'b011, dev_ctrl_o)
        fork i_gia_device_model.send(8'hc5, 1'b0, 1'b0, 0); serve(8'h05); join
        fork i_gia_device_model.send(8'h3c, 1'b1, 1'b0, 0); serve(8'h3c); join
        i_gia_device_model.send(8'h00, 1'b0, 1'b1, 2);
        `CHK("read end", 8'h0e, status_o.data)
        `CHK("data check", 8'h08, sense_o.data)
        `CHK("ctrl off", 3'b000, dev_ctrl_o)
        acc();
        sel(8'h8a, 1'b0);
        `CHK("ctrl4", 3'b100, dev_ctrl_o)
        fork i_gia_device_model.send(8'h11, 1'b0, 1'b0, 3); begin
            wsvc();
            stop_i = 1'b1;
            @(negedge clock_i);
            stop_i = 1'b0;
            repeat (2) @(negedge clock_i);
            `CHK("resp", 1'b0, dev_response_o)
            `CHK("stop end", 8'h0c, status_o.data)
        end join
        acc();
        $display("test read done");
    endtask : t_read
    task automatic t_test_read();
        sel(8'h22, 1'b0);
        `CHK("degated", 3'b000, dev_ctrl_o)
        fork i_gia_device_model_tst.send(8'h05, 1'b0, 1'b0, 0); serve(8'h05); join
        `CHK("dev quiet", 1'b0, dev_response_o)
        halt_i = 1'b1;
        @(negedge clock_i);
        halt_i = 1'b0;
        @(negedge clock_i);
        `CHK("halt", 8'h0c, status_o.data)
        acc();
        $display("test test read done");
    endtask : t_test_read
    initial begin
        {sel_i, bus_out_check_i, status_accept_i, service_grant_i} = '0;
        {bus_in_accept_i, stop_i, halt_i, cmd_i} = '0;
        reset_i = 1'b1;
        repeat (20) @(negedge clock_i);
        reset_i = 1'b0;
        t_select();
        t_read();
        t_test_read();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        complete_run();
    end
endmodule : tb_gia_adapter
